// file: hw/plc_ctrl.sv
// Parallel line controller: 32 pins, AXI4-Lite register slave.
// Assumes pad outputs, peripherals and bus on mclk_in; pad_in is synchronised by two flops.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`include "plc_cfg.svh"
`default_nettype none
module plc_ctrl #(
	parameter logic [31:0] LINE_MASK = `PLC_LINES_DEF,
	parameter logic [31:0] MUX_MASK = `PLC_MUX_DEF,
	parameter logic [31:0] OWNER_RST = `PLC_RST_OWNER
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] pad_in,
	output logic [31:0] pad_out,
	output logic [31:0] pad_oe_out,
	input wire plc_pkg::plc_drive_t periph_a_in,
	input wire plc_pkg::plc_drive_t periph_b_in,
	output logic [31:0] periph_in_out
);
	// =========================================
	// Helpers
	function automatic logic plc_hit(input logic [7:0] addr, input logic [7:0] off);
		plc_hit = (addr[7:2] == off[7:2]);
	endfunction

	function automatic logic [31:0] plc_strb(input logic [3:0] strb);
		plc_strb = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [31:0] plc_setclr(input logic [31:0] cur, input logic [31:0] bits,
			input logic set, input logic clr);
		plc_setclr = cur;
		if (set) begin
			plc_setclr = cur | bits;
		end else if (clr) begin
			plc_setclr = cur & ~bits;
		end
	endfunction

	// =========================================
	// Write channel
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	plc_pkg::plc_resp_t bresp_r;
	logic wr_fire;
	logic [31:0] wbits_c;

	assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
	assign s_axi_wready_out = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign wr_fire = aw_hold_r && w_hold_r;
	assign wbits_c = w_data_r & plc_strb(w_strb_r) & LINE_MASK;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (wr_fire) begin
			aw_hold_r <= 1'b0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_hold_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			w_hold_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (wr_fire) begin
			w_hold_r <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_hold_r <= 1'b1;
			w_data_r <= s_axi_wdata_in;
			w_strb_r <= s_axi_wstrb_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			bvalid_r <= 1'b0;
			bresp_r <= plc_pkg::PLC_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			if (aw_addr_r > `PLC_OFF_TOP) begin
				bresp_r <= plc_pkg::PLC_RESP_SLVERR;
			end else begin
				bresp_r <= plc_pkg::PLC_RESP_OKAY;
			end
		end else if (s_axi_bready_in) begin
			bvalid_r <= 1'b0;
		end
	end

	// =========================================
	// Control registers
	logic [31:0] owner_r;
	logic [31:0] choice_r;
	logic [31:0] drive_r;
	logic [31:0] level_r;
	logic [31:0] mask_r;
	logic [31:0] od_r;
	logic [31:0] filt_r;
	logic [31:0] owner_rst_c;

	assign owner_rst_c = (OWNER_RST | ~MUX_MASK) & LINE_MASK;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			owner_r <= owner_rst_c;
		end else if (wr_fire) begin
			owner_r <= plc_setclr(owner_r, wbits_c & MUX_MASK,
				plc_hit(aw_addr_r, `PLC_OFF_OWN_EN), plc_hit(aw_addr_r, `PLC_OFF_OWN_DIS));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			choice_r <= `PLC_RST_ZERO;
		end else if (wr_fire) begin
			choice_r <= plc_setclr(choice_r, wbits_c,
				plc_hit(aw_addr_r, `PLC_OFF_SEL_B), plc_hit(aw_addr_r, `PLC_OFF_SEL_A));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			drive_r <= `PLC_RST_ZERO;
		end else if (wr_fire) begin
			drive_r <= plc_setclr(drive_r, wbits_c,
				plc_hit(aw_addr_r, `PLC_OFF_DRV_EN), plc_hit(aw_addr_r, `PLC_OFF_DRV_DIS));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			level_r <= `PLC_RST_ZERO;
		end else if (wr_fire && plc_hit(aw_addr_r, `PLC_OFF_LVL_DATA)) begin
			level_r <= (level_r & ~(mask_r & plc_strb(w_strb_r))) | (wbits_c & mask_r);
		end else if (wr_fire) begin
			level_r <= plc_setclr(level_r, wbits_c,
				plc_hit(aw_addr_r, `PLC_OFF_LVL_SET), plc_hit(aw_addr_r, `PLC_OFF_LVL_CLR));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			mask_r <= `PLC_RST_ZERO;
		end else if (wr_fire) begin
			mask_r <= plc_setclr(mask_r, wbits_c,
				plc_hit(aw_addr_r, `PLC_OFF_MSK_SET), plc_hit(aw_addr_r, `PLC_OFF_MSK_CLR));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			od_r <= `PLC_RST_ZERO;
		end else if (wr_fire) begin
			od_r <= plc_setclr(od_r, wbits_c,
				plc_hit(aw_addr_r, `PLC_OFF_OD_EN), plc_hit(aw_addr_r, `PLC_OFF_OD_DIS));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			filt_r <= `PLC_RST_ZERO;
		end else if (wr_fire) begin
			filt_r <= plc_setclr(filt_r, wbits_c,
				plc_hit(aw_addr_r, `PLC_OFF_FLT_EN), plc_hit(aw_addr_r, `PLC_OFF_FLT_DIS));
		end
	end

	// =========================================
	// Pin sampling and filter
	logic [31:0] sync1_r;
	logic [31:0] sync2_r;
	logic [31:0] dly_r;
	logic [31:0] pin_view_r;
	logic [31:0] view_c;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			sync1_r <= `PLC_RST_ZERO;
			sync2_r <= `PLC_RST_ZERO;
		end else begin
			sync1_r <= pad_in;
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			dly_r <= `PLC_RST_ZERO;
			pin_view_r <= `PLC_RST_ZERO;
		end else if (clk_en_in) begin
			dly_r <= sync2_r;
			pin_view_r <= view_c & LINE_MASK;
		end
	end

	assign periph_in_out = sync2_r;

	// =========================================
	// Per-line output path
	logic [31:0] lvl_c;
	logic [31:0] en_c;
	logic [31:0] pad_out_r;
	logic [31:0] pad_oe_r;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_line
			logic p_lvl;
			logic p_en;
			assign view_c[gi] = filt_r[gi] ? dly_r[gi] : sync2_r[gi];
			assign p_lvl = choice_r[gi] ? periph_b_in.level[gi] : periph_a_in.level[gi];
			assign p_en = choice_r[gi] ? periph_b_in.enable[gi] : periph_a_in.enable[gi];
			assign lvl_c[gi] = owner_r[gi] ? level_r[gi] : p_lvl;
			assign en_c[gi] = (owner_r[gi] ? drive_r[gi] : p_en) && !(od_r[gi] && lvl_c[gi]);
		end
	endgenerate

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pad_out_r <= `PLC_RST_ZERO;
			pad_oe_r <= `PLC_RST_ZERO;
		end else begin
			pad_out_r <= lvl_c & LINE_MASK;
			pad_oe_r <= en_c & LINE_MASK;
		end
	end

	assign pad_out = pad_out_r;
	assign pad_oe_out = pad_oe_r;

	// =========================================
	// Read channel
	logic rvalid_r;
	logic [31:0] rdata_r;
	plc_pkg::plc_resp_t rresp_r;
	logic [31:0] rd_c;

	assign s_axi_arready_out = !rvalid_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;

	always_comb begin
		if (plc_hit(s_axi_araddr_in, `PLC_OFF_OWN_STAT)) begin
			rd_c = owner_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_DRV_STAT)) begin
			rd_c = drive_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_FLT_STAT)) begin
			rd_c = filt_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_LVL_DATA)) begin
			rd_c = level_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_PIN_VIEW)) begin
			rd_c = pin_view_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_OD_STAT)) begin
			rd_c = od_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_MSK_STAT)) begin
			rd_c = mask_r;
		end else if (plc_hit(s_axi_araddr_in, `PLC_OFF_SEL_STAT)) begin
			rd_c = choice_r;
		end else begin
			rd_c = `PLC_RST_ZERO;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rvalid_r <= 1'b0;
			rdata_r <= `PLC_RST_ZERO;
			rresp_r <= plc_pkg::PLC_RESP_OKAY;
		end else if (s_axi_arvalid_in && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_c & LINE_MASK;
			if (s_axi_araddr_in > `PLC_OFF_TOP) begin
				rresp_r <= plc_pkg::PLC_RESP_SLVERR;
			end else begin
				rresp_r <= plc_pkg::PLC_RESP_OKAY;
			end
		end else if (s_axi_rready_in) begin
			rvalid_r <= 1'b0;
		end
	end

	// =========================================
	// Checks
	logic [31:0] pa_en_w;
	assign pa_en_w = periph_a_in.enable;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);

	sequence s_wr(logic [7:0] off);
		wr_fire && plc_hit(aw_addr_r, off);
	endsequence

	sequence s_filt_run;
		clk_en_in [*2];
	endsequence

	property p_owner_set;
		s_wr(`PLC_OFF_OWN_EN) |=> ((owner_r & $past(wbits_c) & MUX_MASK) == ($past(wbits_c) & MUX_MASK));
	endproperty
	a_owner_set: assert property (p_owner_set) else $error("ownership not set");

	property p_owner_fixed;
		(owner_r & ~MUX_MASK & LINE_MASK) == (~MUX_MASK & LINE_MASK);
	endproperty
	a_owner_fixed: assert property (p_owner_fixed) else $error("plain line lost ownership");

	property p_choice_clr;
		s_wr(`PLC_OFF_SEL_A) |=> ((choice_r & $past(wbits_c)) == 32'h0000_0000);
	endproperty
	a_choice_clr: assert property (p_choice_clr) else $error("choice not cleared");

	property p_reset;
		disable iff (1'b0) srst_in |=> (choice_r == 32'h0000_0000 && mask_r == 32'h0000_0000 &&
			od_r == 32'h0000_0000 && owner_r == owner_rst_c);
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");

	property p_periph;
		##1 (((pad_oe_out ^ $past(pa_en_w)) & ~$past(owner_r) & ~$past(choice_r) & ~$past(od_r) & LINE_MASK)
			== 32'h0000_0000);
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral A not driving");

	property p_drive_set;
		s_wr(`PLC_OFF_DRV_EN) |=> ((drive_r & $past(wbits_c)) == $past(wbits_c));
	endproperty
	a_drive_set: assert property (p_drive_set) else $error("drive not set");

	property p_direct;
		s_wr(`PLC_OFF_LVL_DATA) |=> (((level_r ^ $past(level_r)) & ~$past(mask_r)) == 32'h0000_0000);
	endproperty
	a_direct: assert property (p_direct) else $error("masked level changed");

	property p_od;
		##1 ((pad_oe_out & pad_out & $past(od_r)) == 32'h0000_0000);
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high");

	property p_hold;
		!clk_en_in |=> $stable(pin_view_r);
	endproperty
	a_hold: assert property (p_hold) else $error("pin view moved while gated");

	property p_filt;
		s_filt_run |=> (((pin_view_r ^ $past(sync2_r, 2)) & $past(filt_r) & LINE_MASK) == 32'h0000_0000);
	endproperty
	a_filt: assert property (p_filt) else $error("filter latency wrong");
endmodule
`default_nettype wire

// file: inc/plc_cfg.svh
// Offsets, reset values and default line masks of the parallel line controller.
// Assumes byte addressing, one aligned 32-bit word per register.
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH
`define PLC_OFF_OWN_EN 8'h00
`define PLC_OFF_OWN_DIS 8'h04
`define PLC_OFF_OWN_STAT 8'h08
`define PLC_OFF_DRV_EN 8'h10
`define PLC_OFF_DRV_DIS 8'h14
`define PLC_OFF_DRV_STAT 8'h18
`define PLC_OFF_FLT_EN 8'h20
`define PLC_OFF_FLT_DIS 8'h24
`define PLC_OFF_FLT_STAT 8'h28
`define PLC_OFF_LVL_SET 8'h30
`define PLC_OFF_LVL_CLR 8'h34
`define PLC_OFF_LVL_DATA 8'h38
`define PLC_OFF_PIN_VIEW 8'h3C
`define PLC_OFF_OD_EN 8'h50
`define PLC_OFF_OD_DIS 8'h54
`define PLC_OFF_OD_STAT 8'h58
`define PLC_OFF_MSK_SET 8'h60
`define PLC_OFF_MSK_CLR 8'h64
`define PLC_OFF_MSK_STAT 8'h68
`define PLC_OFF_SEL_A 8'h70
`define PLC_OFF_SEL_B 8'h74
`define PLC_OFF_SEL_STAT 8'h78
`define PLC_OFF_TOP 8'h7C
`define PLC_RST_ZERO 32'h0000_0000
`define PLC_RST_OWNER 32'hFFFF_FFFF
`define PLC_LINES_DEF 32'hFFFF_FFFF
`define PLC_MUX_DEF 32'hFFFF_FFFF
`endif

// file: inc/plc_pkg.sv
// Types shared by the parallel line controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package plc_pkg;
	typedef enum logic [1:0] {
		PLC_RESP_OKAY = 2'h0,
		PLC_RESP_SLVERR = 2'h2
	} plc_resp_t;
	typedef struct packed {
		logic [31:0] level;
		logic [31:0] enable;
	} plc_drive_t;
endpackage
`default_nettype wire

// file: sim/plc_far_pins.sv
// Far-side pins: resolves each pad level from controller and outside drivers.
// Assumes a pull-up on every line; the controller wins a clash.
`default_nettype none
module plc_far_pins (
	input wire logic [31:0] drv_lvl_in,
	input wire logic [31:0] drv_oe_in,
	input wire logic [31:0] ext_lvl_in,
	input wire logic [31:0] ext_oe_in,
	output logic [31:0] pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lines released by both controller and outside drivers float to the pull-up
	assign pin_out = (drv_oe_in & drv_lvl_in) | (~drv_oe_in & ext_oe_in & ext_lvl_in) | (~drv_oe_in & ~ext_oe_in);
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the parallel line controller.
// Assumes plc_ctrl with default parameters and plc_far_pins on the pads.
`include "plc_cfg.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 1'b0;
	logic srst_in, clk_en, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv;
	logic [7:0] awa, ara;
	logic [1:0] br, rr, r;
	logic [31:0] wd, rdat, pin, pout, poe, pfb, xl, xo, d, a, b, v;
	logic [63:0] e;
	plc_pkg::plc_drive_t pa, pb;
	logic [31:0] st [7];
	logic [7:0] so [7] = '{`PLC_OFF_OWN_EN, `PLC_OFF_DRV_EN, `PLC_OFF_FLT_EN, `PLC_OFF_LVL_SET, `PLC_OFF_OD_EN,
		`PLC_OFF_MSK_SET, `PLC_OFF_SEL_B};
	logic [7:0] co [7] = '{`PLC_OFF_OWN_DIS, `PLC_OFF_DRV_DIS, `PLC_OFF_FLT_DIS, `PLC_OFF_LVL_CLR, `PLC_OFF_OD_DIS,
		`PLC_OFF_MSK_CLR, `PLC_OFF_SEL_A};
	logic [7:0] ro [7] = '{`PLC_OFF_OWN_STAT, `PLC_OFF_DRV_STAT, `PLC_OFF_FLT_STAT, `PLC_OFF_LVL_DATA,
		`PLC_OFF_OD_STAT, `PLC_OFF_MSK_STAT, `PLC_OFF_SEL_STAT};
	integer errors = 0, check_count = 0, seed = 69, i, k;
	always #10 mclk_in = ~mclk_in;
	plc_ctrl plc_ctrl_inst (.mclk_in(mclk_in), .srst_in(srst_in), .clk_en_in(clk_en),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(br),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rre), .pad_in(pin), .pad_out(pout), .pad_oe_out(poe), .periph_a_in(pa),
		.periph_b_in(pb), .periph_in_out(pfb));
	plc_far_pins plc_far_pins_inst (.drv_lvl_in(pout), .drv_oe_in(poe), .ext_lvl_in(xl), .ext_oe_in(xo),
		.pin_out(pin));
	// ====
	// Report and bus tasks
	task automatic final_report;
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic tout;
		errors++;
		final_report();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		logic ta, tw, tb;
		int n;
		@(posedge mclk_in);
		awa <= ad;
		wd <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge mclk_in);
			ta = awv & awr;
			tw = wv & wrdy;
			tb = bv;
			r = br;
			@(posedge mclk_in);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) break;
		end
		bre <= 1'b0;
		if (n == 50) tout();
	endtask
	task automatic rd(input logic [7:0] ad);
		logic ta, tv;
		int n;
		@(posedge mclk_in);
		ara <= ad;
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge mclk_in);
			ta = arv & arr;
			tv = rv;
			d = rdat;
			r = rr;
			@(posedge mclk_in);
			if (ta) arv <= 1'b0;
			if (tv) break;
		end
		rre <= 1'b0;
		if (n == 50) tout();
	endtask
	function automatic logic [63:0] pads_exp();
		logic [31:0] lv, en;
		lv = (st[0] & st[3]) | (~st[0] & ~st[6] & pa.level) | (~st[0] & st[6] & pb.level);
		en = (st[0] & st[1]) | (~st[0] & ~st[6] & pa.enable) | (~st[0] & st[6] & pb.enable);
		return {en & ~(st[4] & lv), lv};
	endfunction
	// ====
	// Main sequence
	initial begin
		srst_in = 1'b1;
		clk_en = 1'b1;
		{awv, wv, bre, arv, rre} = 5'h00;
		{awa, ara, wd, xl, xo} = '0;
		pa = '0;
		pb = '0;
		st = '{0: `PLC_RST_OWNER, default: `PLC_RST_ZERO};
		repeat (5) @(posedge mclk_in);
		srst_in <= 1'b0;
		for (i = 0; i < 7; i++) begin
			rd(ro[i]);
			chk(d, st[i]);
		end
		for (k = 0; k < 6; k++) begin
			for (i = 0; i < 7; i++) begin
				a = $random(seed);
				b = $random(seed);
				wr(so[i], a);
				wr(co[i], b);
				st[i] = (st[i] | a) & ~b;
				rd(ro[i]);
				chk(d, st[i]);
			end
			a = $random(seed);
			wr(`PLC_OFF_LVL_DATA, a);
			st[3] = (st[3] & ~st[5]) | (a & st[5]);
			rd(`PLC_OFF_LVL_DATA);
			chk(d, st[3]);
			pa <= {$random(seed), $random(seed)};
			pb <= {$random(seed), $random(seed)};
			xl <= $random(seed);
			xo <= $random(seed);
			repeat (3) @(posedge mclk_in);
			@(negedge mclk_in);
			e = pads_exp();
			chk(poe, e[63:32]);
			chk(pout & e[63:32], e[31:0] & e[63:32]);
			repeat (4) @(posedge mclk_in);
			rd(`PLC_OFF_PIN_VIEW);
			chk(d, pin);
			chk(pfb, pin);
		end
		v = pin;
		@(posedge mclk_in);
		clk_en <= 1'b0;
		xl <= ~pin;
		xo <= 32'hFFFF_FFFF;
		repeat (6) @(posedge mclk_in);
		rd(`PLC_OFF_PIN_VIEW);
		chk(d, v);
		clk_en <= 1'b1;
		wr(`PLC_OFF_TOP + 8'h04, 32'hFFFF_FFFF);
		chk({30'h0, r}, 32'(plc_pkg::PLC_RESP_SLVERR));
		rd(`PLC_OFF_TOP + 8'h04);
		chk({30'h0, r}, 32'(plc_pkg::PLC_RESP_SLVERR));
		rd(`PLC_OFF_OWN_STAT + 8'h04);
		chk(d, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
